/* File: bench/smsp_partner.sv */
/*
  External serial device: slave to a master port, master to a slave port.
  Assumes the bench sets polarity and phase before each transfer.
*/
`timescale 1ns/1ns
module smsp_partner (
  input wire logic sys_clk,
  input wire smsp_pkg::smsp_pin_out_type pin_out,
  output wire smsp_pkg::smsp_pin_in_type pin_in
);
  logic clock_idle_level = 1'b0;
  logic clock_launch_edge = 1'b0;
  logic [7:0] sh = 8'h00;
  logic [7:0] rx = 8'h00;
  logic [2:0] cnt = 3'h0;
  logic m_sclk = 1'b0;
  logic m_mosi = 1'b0;
  logic sel_n = 1'b1;
  logic tog = 1'b0;
  // Released lines wander, so a stale level never looks valid
  always @(posedge sys_clk) tog <= ~tog;
  // Wire levels from every party's enables
  assign pin_in.sclk = pin_out.sclk_oe ? pin_out.sclk_o : m_sclk;
  assign pin_in.mosi = pin_out.mosi_oe ? pin_out.mosi_o : (sel_n ? tog : m_mosi);
  assign pin_in.miso = pin_out.miso_oe ? pin_out.miso_o : (pin_out.sclk_oe ? sh[7] : tog);
  assign pin_in.sel_n = sel_n;
  // Slave side: launch and capture on opposite edges, first launch keeps bit 7 only when launching on the leading edge
  always @(pin_in.sclk) begin
    if (pin_out.sclk_oe) begin
      if ((pin_in.sclk != clock_idle_level) == clock_launch_edge) begin
        if (!clock_launch_edge || cnt != 3'h0) sh = {sh[6:0], 1'b0};
      end else begin
        rx = {rx[6:0], pin_in.mosi};
        cnt = cnt + 3'h1;
      end
    end
  end
  task automatic load(input logic [7:0] b);
    sh = b;
    cnt = 3'h0;
  endtask
  // Master side: select lowered before the byte and left low, eight core clocks per half period
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx_o);
    sel_n = 1'b0;
    m_mosi = tx[7];
    for (int i = 0; i < 8; i++) begin
      repeat (8) @(negedge sys_clk);
      m_sclk = ~clock_idle_level;
      if (clock_launch_edge) m_mosi = tx[7-i]; else rx_o[7-i] = pin_in.miso;
      repeat (8) @(negedge sys_clk);
      m_sclk = clock_idle_level;
      if (clock_launch_edge) rx_o[7-i] = pin_in.miso; else if (i < 7) m_mosi = tx[6-i];
    end
    repeat (8) @(negedge sys_clk);
  endtask
endmodule

/* File: bench/smsp_port_asserts.sv */
/*
  Checker for the serial port pins and the register port.
  Assumes it is bound to smsp_port, with one clock domain.
*/
`timescale 1ns/1ns
module smsp_port_asserts (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  input wire logic pins_owned,
  input wire smsp_pkg::smsp_pin_in_type pin_in,
  input wire smsp_pkg::smsp_pin_out_type pin_out
);
  logic cwr;
  logic dwr;
  logic sclk_q_ff;
  logic [1:0] cwr_q_ff;
  logic [4:0] edge_ff;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  // Register strobes by target
  assign cwr = sfr_wr && sfr_addr == smsp_pkg::ADDR_CTRL;
  assign dwr = sfr_wr && sfr_addr == smsp_pkg::ADDR_DATA;
  // Last clock level, for edge detection
  always_ff @(posedge sys_clk) begin
    sclk_q_ff <= pin_out.sclk_o;
  end
  // Config writes of the last two cycles; the idle level settles within them
  always_ff @(posedge sys_clk) begin
    cwr_q_ff <= {cwr_q_ff[0], cwr};
  end
  // Driven edges per burst; a mid-burst data write must not restart the count
  always_ff @(posedge sys_clk) begin
    if (!nrst || cwr || cwr_q_ff != 2'h0 || (dwr && edge_ff[3:0] == 4'h0)) begin
      edge_ff <= 5'h00;
    end else if (pin_out.sclk_oe && pin_out.sclk_o != sclk_q_ff) begin
      edge_ff <= edge_ff + 5'h01;
    end
  end
  AST_MISO_DIR: assert property (pin_out.miso_oe |-> !pin_out.sclk_oe)
    else $error("miso driven while master");
  AST_MOSI_DIR: assert property (pin_out.mosi_oe == pin_out.sclk_oe)
    else $error("mosi enable differs from master clock enable");
  AST_PINS_FREE: assert property ((pin_out.sclk_oe || pin_out.miso_oe) |-> pins_owned)
    else $error("pins driven while port disabled");
  AST_ENABLE_WR: assert property (cwr |=> pins_owned == $past(sfr_wdata[5]))
    else $error("enable bit not applied");
  AST_MASTER_WR: assert property (cwr |=> pin_out.sclk_oe == $past(sfr_wdata[5] && sfr_wdata[4]))
    else $error("clock direction wrong after control write");
  AST_MISO_FREE: assert property (pin_in.sel_n [*4] |-> !pin_out.miso_oe)
    else $error("miso still driven with select high");
  AST_BURST: assert property (edge_ff <= 5'h10)
    else $error("more than sixteen clock edges in a burst");
  AST_LAUNCH: assert property (pin_out.sclk_oe && $stable(pin_out.sclk_oe) && $stable(pin_out.sclk_o)
    && $changed(pin_out.mosi_o) |-> $past(sfr_wr))
    else $error("mosi moved without a clock edge");
  cover property (dwr && pin_out.sclk_oe);
  cover property (pin_out.miso_oe && pins_owned);
  cover property (cwr && sfr_wdata[4]);
endmodule

bind smsp_port smsp_port_asserts u_chk (.sys_clk(sys_clk), .nrst(nrst), .sfr_addr(sfr_addr),
  .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
  .pins_owned(pins_owned), .pin_in(pin_in), .pin_out(pin_out));

/* File: bench/smsp_port_test.sv */
/*
  Self-checking bench for the serial port in master and slave mode.
  Assumes the partner model resolves the shared pins.
*/
`timescale 1ns/1ns
module smsp_port_test;
  logic sys_clk;
  logic nrst = 1'b0;
  logic [7:0] sfr_addr = 8'h00;
  logic sfr_wr = 1'b0;
  logic sfr_rd = 1'b0;
  logic [7:0] sfr_wdata = 8'h00;
  logic [7:0] sfr_rdata;
  logic pins_owned;
  smsp_pkg::smsp_pin_in_type pin_in;
  smsp_pkg::smsp_pin_out_type pin_out;
  int failures = 0;
  int cmp_count = 0;
  smsp_port uut (.sys_clk(sys_clk), .nrst(nrst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .pins_owned(pins_owned),
    .pin_in(pin_in), .pin_out(pin_out));
  smsp_partner p (.sys_clk(sys_clk), .pin_out(pin_out), .pin_in(pin_in));
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  // Two cycles per access, so strobes never change twice in one step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge sys_clk);
    sfr_wr = 1'b0;
    @(negedge sys_clk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(negedge sys_clk);
    sfr_rd = 1'b0;
    @(negedge sys_clk);
    d = sfr_rdata;
  endtask
  task automatic t_reset();
    logic [7:0] v;
    rd(smsp_pkg::ADDR_CTRL, v);
    chk("ctrl reset", smsp_pkg::RST_CTRL & 8'hfe, v & 8'hfe);
    rd(smsp_pkg::ADDR_DATA, v);
    chk("data reset", smsp_pkg::RST_DATA, v);
    rd(8'h10, v);
    chk("unmapped read", 8'h00, v);
  endtask
  // Mode and rate from the index; a colliding write lands mid-burst
  task automatic t_master(input int i);
    logic [7:0] v;
    int h;
    h = 1 << i;
    p.clock_idle_level = i[0];
    p.clock_launch_edge = i[1];
    p.sel_n = ~i[0];
    wr(smsp_pkg::ADDR_CTRL, {4'h3, i[0], i[1], i[1:0]});
    repeat (2) @(negedge sys_clk);
    chk("sclk idle", {7'h00, i[0]}, {7'h00, pin_in.sclk});
    rd(smsp_pkg::ADDR_CTRL, v);
    chk("flags cleared by write", 8'h00, v & 8'hc0);
    p.load(8'h5a ^ 8'(i));
    wr(smsp_pkg::ADDR_DATA, 8'hc3 ^ 8'(i));
    repeat (8 * h - 2) @(negedge sys_clk);
    wr(smsp_pkg::ADDR_DATA, 8'hff);
    repeat (8 * h - 2) @(negedge sys_clk);
    rd(smsp_pkg::ADDR_CTRL, v);
    chk("done early", 8'h40, v & 8'hc0);
    rd(smsp_pkg::ADDR_CTRL, v);
    chk("done set", 8'hc0, v & 8'hc0);
    chk("partner rx", 8'hc3 ^ 8'(i), p.rx);
    rd(smsp_pkg::ADDR_DATA, v);
    chk("master rx", 8'h5a ^ 8'(i), v);
    rd(smsp_pkg::ADDR_CTRL, v);
    chk("flags after read", 8'h40, v & 8'hc0);
  endtask
  // Phase zero must hold the byte until select rises
  task automatic t_slave(input int i);
    logic [7:0] v;
    logic [7:0] r;
    p.clock_idle_level = i[0];
    p.clock_launch_edge = i[1];
    p.m_sclk = i[0];
    p.sel_n = 1'b1;
    wr(smsp_pkg::ADDR_CTRL, {4'h2, i[0], i[1], 2'h0});
    rd(smsp_pkg::ADDR_CTRL, v);
    chk("select high", 8'h01, v & 8'h01);
    wr(smsp_pkg::ADDR_DATA, 8'h96 ^ 8'(i));
    p.xfer(8'h69 ^ 8'(i), r);
    rd(smsp_pkg::ADDR_CTRL, v);
    chk("done before release", {i[1], 7'h00}, v & 8'h81);
    p.sel_n = 1'b1;
    repeat (6) @(negedge sys_clk);
    rd(smsp_pkg::ADDR_DATA, v);
    chk("slave rx", 8'h69 ^ 8'(i), v);
    chk("slave tx", 8'h96 ^ 8'(i), r);
    rd(smsp_pkg::ADDR_CTRL, v);
    chk("done cleared", 8'h01, v & 8'h81);
  endtask
  // Clearing the enable bit hands every pin back, even with master set
  task automatic t_release();
    wr(smsp_pkg::ADDR_CTRL, 8'h10);
    chk("pins owned", 8'h00, {7'h00, pins_owned});
    chk("pin enables", 8'h00, {5'h00, pin_out.sclk_oe, pin_out.mosi_oe, pin_out.miso_oe});
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // Whole run is near 9 us; give it over ten times that
  initial begin
    #100000;
    failures++;
    end_sim();
  end
  initial begin
    repeat (8) @(negedge sys_clk);
    nrst = 1'b1;
    t_reset();
    for (int i = 0; i < 4; i++) t_master(i);
    for (int i = 0; i < 4; i++) t_slave(i);
    t_release();
    end_sim();
  end
endmodule

/* File: design/smsp_pkg.sv */
/*
  Shared constants and types of the serial master/slave port: register
  offsets, control field positions, reset values and pin carriers.
  Assumes it is compiled before every file that uses it.
*/
package smsp_pkg;

  // Register offsets on the core special-function port
  localparam logic [7:0] ADDR_DATA = 8'hf7;
  localparam logic [7:0] ADDR_CTRL = 8'hf8;

  // Reset values
  localparam logic [7:0] RST_DATA = 8'h00;
  localparam logic [7:0] RST_CTRL = 8'h04;

  // Control field positions
  localparam int BIT_DONE = 7;
  localparam int BIT_WRITE_COLLISION_FLAG = 6;
  localparam int BIT_ENABLE = 5;
  localparam int BIT_MASTER = 4;
  localparam int BIT_IDLE_LVL = 3;
  localparam int BIT_PHASE = 2;
  localparam int BIT_RATE_HI = 1;
  localparam int BIT_RATE_LO = 0;

  // Bits per transfer and clock edges per master burst
  localparam logic [3:0] BITS_PER_XFER = 4'h8;
  localparam logic [4:0] EDGES_PER_XFER = 5'h10;

  // Master engine state
  typedef enum logic {
    SMSP_IDLE,
    SMSP_RUN
  } smsp_state_type;

  // Levels seen on the shared pins
  typedef struct packed {
    logic sclk;
    logic mosi;
    logic miso;
    logic sel_n;
  } smsp_pin_in_type;

  // Drive values and enables toward the shared pins
  typedef struct packed {
    logic sclk_o;
    logic sclk_oe;
    logic mosi_o;
    logic mosi_oe;
    logic miso_o;
    logic miso_oe;
  } smsp_pin_out_type;

endpackage

/* File: design/smsp_port.sv */
/*
  Byte-wide full-duplex serial port, master or slave, with its control and
  data registers on the core special-function port.
  Assumes pin inputs are asynchronous to sys_clk and that the pad logic
  resolves each pin from the drive value and enable given here.
*/
`timescale 1ns/1ns

// Functional notes
// RQ1 - Eight bits each way per transfer, most significant bit first.
// RQ2 - Master-in line is input as master, driven output as slave.
// RQ3 - Master-out line is driven as master, input as slave.
// RQ4 - Serial clock is driven as master, received as slave.
// RQ5 - One bit out and in per clock period, launch and capture on opposite edges.
// RQ6 - Slave shifts only while select is low; select ignored as master.
// RQ7 - External master frames each byte with select when phase is zero.
// RQ8 - As slave, control bit 0 reads back the select pin level.
// RQ9 - Done flag sets at transfer end; cleared by writing zero or reading data.
// RQ10 - Collision flag sets on data write during transfer; software clears it.
// RQ11 - Enable bit hands the shared pins to this port, else releases them.
// RQ12 - Control bit 4 selects master with clock output, else slave.
// RQ13 - Control bit 3 sets the clock idle level.
// RQ14 - Control bit 2 set launches on leading edge, cleared on trailing.
// RQ15 - Master rate bits divide core clock by 2, 4, 8 or 16.
// RQ16 - Master data write starts a burst of exactly eight clocks.
// RQ17 - Master ignores select input and drives no select.
// RQ18 - After eighth master clock, received byte goes to data register, flag sets.
// RQ19 - Slave data write loads the byte to send; shifts on incoming clocks.
// RQ20 - Slave latches byte after eighth clock, or on select rise with phase zero.
// RQ21 - Slave releases master-in line while select is high.
// RQ22 - A colliding data write leaves the running transfer untouched.
module smsp_port (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  output logic pins_owned,
  input wire smsp_pkg::smsp_pin_in_type pin_in,
  output smsp_pkg::smsp_pin_out_type pin_out
);

  logic [5:0] cfg_ff;
  logic done_ff;
  logic write_collision_flag_ff;
  logic [7:0] data_ff;
  logic [7:0] tx_ff;
  logic [7:0] rx_ff;
  logic [7:0] rdata_ff;
  logic [3:0] bit_cnt_ff;
  logic [4:0] edge_cnt_ff;
  logic [3:0] div_cnt_ff;
  logic sclk_ff;
  smsp_pkg::smsp_state_type state_ff;
  logic [2:0] sync1_ff;
  logic [2:0] sync2_ff;
  logic sclk_last_ff;
  logic sel_last_ff;

  logic [7:0] ctrl;
  logic enable;
  logic master;
  logic idle_lvl;
  logic phase;
  logic [3:0] half_period;
  logic s_sclk;
  logic s_mosi;
  logic s_sel_n;
  logic selected;
  logic tick;
  logic lead_ev;
  logic trail_ev;
  logic sample_ev;
  logic launch_ev;
  logic done_ev;
  logic busy;
  logic wr_data;
  logic wr_ctrl;
  logic rd_data;
  logic sample_bit;
  logic [7:0] nxt_rx;

  // Control view; flags and settings sit in separate registers, one driver each
  assign ctrl = {done_ff, write_collision_flag_ff, cfg_ff};
  assign enable = ctrl[smsp_pkg::BIT_ENABLE];
  assign master = ctrl[smsp_pkg::BIT_MASTER]; // RQ12
  assign idle_lvl = ctrl[smsp_pkg::BIT_IDLE_LVL];
  assign phase = ctrl[smsp_pkg::BIT_PHASE];
  assign pins_owned = enable; // RQ11

  // Register port strobes
  assign wr_data = sfr_wr && (sfr_addr == smsp_pkg::ADDR_DATA);
  assign wr_ctrl = sfr_wr && (sfr_addr == smsp_pkg::ADDR_CTRL);
  assign rd_data = sfr_rd && (sfr_addr == smsp_pkg::ADDR_DATA);

  // Half a bit period in core clocks: 1, 2, 4 or 8
  assign half_period = 4'h1 << ctrl[smsp_pkg::BIT_RATE_HI:smsp_pkg::BIT_RATE_LO]; // RQ15

  // Pin synchronisers; only the second stage is read
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      sync1_ff <= 3'h7;
      sync2_ff <= 3'h7;
    end else begin
      sync1_ff <= {pin_in.sclk, pin_in.mosi, pin_in.sel_n};
      sync2_ff <= sync1_ff;
    end
  end

  assign s_sclk = sync2_ff[2];
  assign s_mosi = sync2_ff[1];
  assign s_sel_n = sync2_ff[0];

  // Previous synchronised levels; reset matches the synchroniser, no false edge
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      sclk_last_ff <= 1'b1;
      sel_last_ff <= 1'b1;
    end else begin
      sclk_last_ff <= s_sclk;
      sel_last_ff <= s_sel_n;
    end
  end

  // Slave listens only with select low; master never looks at it
  assign selected = enable && !master && !s_sel_n; // RQ6 RQ17

  // Master bit-rate divider reaches a clock edge
  assign tick = (state_ff == smsp_pkg::SMSP_RUN) && (div_cnt_ff == half_period - 4'h1);

  // Leading and trailing edges from either clock source
  always_comb begin
    lead_ev = 1'b0;
    trail_ev = 1'b0;
    if (master) begin
      lead_ev = tick && !edge_cnt_ff[0];
      trail_ev = tick && edge_cnt_ff[0];
    end else if (selected && (s_sclk != sclk_last_ff)) begin
      lead_ev = (sclk_last_ff == idle_lvl);
      trail_ev = (sclk_last_ff != idle_lvl);
    end
  end

  // Launch on one edge, capture on the other
  assign launch_ev = phase ? lead_ev : trail_ev; // RQ5 RQ14
  assign sample_ev = phase ? trail_ev : lead_ev; // RQ5 RQ14
  assign sample_bit = master ? pin_in.miso : s_mosi;
  assign nxt_rx = {rx_ff[6:0], sample_bit}; // RQ1

  // Transfer end for each mode
  always_comb begin
    done_ev = 1'b0;
    if (master) begin
      done_ev = tick && (edge_cnt_ff == smsp_pkg::EDGES_PER_XFER - 5'h01); // RQ16 RQ18
    end else if (enable && phase) begin
      done_ev = sample_ev && (bit_cnt_ff == smsp_pkg::BITS_PER_XFER - 4'h1); // RQ20
    end else if (enable) begin
      done_ev = s_sel_n && !sel_last_ff && (bit_cnt_ff == smsp_pkg::BITS_PER_XFER); // RQ20
    end
  end

  // A transfer is under way once bits are moving
  assign busy = master ? (state_ff == smsp_pkg::SMSP_RUN)
              : (!s_sel_n && bit_cnt_ff != 4'h0 && bit_cnt_ff != smsp_pkg::BITS_PER_XFER);

  // Master engine state; a mode change aborts a running burst
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      state_ff <= smsp_pkg::SMSP_IDLE;
    end else if (!enable || !master) begin
      state_ff <= smsp_pkg::SMSP_IDLE;
    end else if (state_ff == smsp_pkg::SMSP_IDLE && wr_data) begin
      state_ff <= smsp_pkg::SMSP_RUN; // RQ16
    end else if (done_ev) begin
      state_ff <= smsp_pkg::SMSP_IDLE;
    end
  end

  // Divider and edge count of the master burst
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      div_cnt_ff <= 4'h0;
      edge_cnt_ff <= 5'h00;
    end else if (state_ff != smsp_pkg::SMSP_RUN) begin
      div_cnt_ff <= 4'h0;
      edge_cnt_ff <= 5'h00;
    end else if (tick) begin
      div_cnt_ff <= 4'h0;
      edge_cnt_ff <= edge_cnt_ff + 5'h01; // RQ16
    end else begin
      div_cnt_ff <= div_cnt_ff + 4'h1;
    end
  end

  // Master clock rests at the idle level between bursts
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      sclk_ff <= 1'b0;
    end else if (state_ff != smsp_pkg::SMSP_RUN) begin
      sclk_ff <= idle_lvl; // RQ13
    end else if (tick) begin
      sclk_ff <= !sclk_ff;
    end
  end

  // Captured bit count; a high select restarts the slave count
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      bit_cnt_ff <= 4'h0;
    end else if (master ? (state_ff != smsp_pkg::SMSP_RUN) : s_sel_n) begin
      bit_cnt_ff <= 4'h0; // RQ6
    end else if (!master && phase && done_ev) begin
      bit_cnt_ff <= 4'h0; // Select may stay low between bytes
    end else if (sample_ev && bit_cnt_ff != smsp_pkg::BITS_PER_XFER) begin
      bit_cnt_ff <= bit_cnt_ff + 4'h1;
    end
  end

  // Outgoing byte: loaded only when idle so a collision leaves it intact
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      tx_ff <= smsp_pkg::RST_DATA;
    end else if (wr_data && !busy) begin
      tx_ff <= sfr_wdata; // RQ19
    end else if (launch_ev && (!phase || bit_cnt_ff != 4'h0)) begin
      tx_ff <= {tx_ff[6:0], 1'b0}; // RQ1 RQ5
    end
  end

  // Incoming shift register
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      rx_ff <= smsp_pkg::RST_DATA;
    end else if (sample_ev) begin
      rx_ff <= nxt_rx; // RQ19
    end
  end

  // Data register: software byte, replaced by the received byte at the end
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      data_ff <= smsp_pkg::RST_DATA;
    end else if (done_ev) begin
      data_ff <= (sample_ev ? nxt_rx : rx_ff); // RQ18 RQ20
    end else if (wr_data && !busy) begin
      data_ff <= sfr_wdata; // RQ22
    end
  end

  // Configuration bits written by software
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      cfg_ff <= smsp_pkg::RST_CTRL[5:0];
    end else if (wr_ctrl) begin
      cfg_ff <= sfr_wdata[5:0]; // RQ11 RQ12 RQ13 RQ14 RQ15
    end
  end

  // Done flag: hardware set wins over a clear in the same cycle
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      done_ff <= smsp_pkg::RST_CTRL[smsp_pkg::BIT_DONE];
    end else if (done_ev) begin
      done_ff <= 1'b1; // RQ9
    end else if ((wr_ctrl && !sfr_wdata[smsp_pkg::BIT_DONE]) || rd_data) begin
      done_ff <= 1'b0; // RQ9
    end
  end

  // Collision flag: set by a busy write, cleared only by software
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      write_collision_flag_ff <= smsp_pkg::RST_CTRL[smsp_pkg::BIT_WRITE_COLLISION_FLAG];
    end else if (wr_data && busy) begin
      write_collision_flag_ff <= 1'b1; // RQ10
    end else if (wr_ctrl && !sfr_wdata[smsp_pkg::BIT_WRITE_COLLISION_FLAG]) begin
      write_collision_flag_ff <= 1'b0; // RQ10
    end
  end

  // Read data registered one cycle after the strobe
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      rdata_ff <= 8'h00;
    end else if (sfr_rd) begin
      if (sfr_addr == smsp_pkg::ADDR_DATA) begin
        rdata_ff <= data_ff;
      end else if (sfr_addr == smsp_pkg::ADDR_CTRL) begin
        rdata_ff <= master ? ctrl : {ctrl[7:1], s_sel_n}; // RQ8
      end else begin
        rdata_ff <= 8'h00;
      end
    end
  end

  assign sfr_rdata = rdata_ff;

  // Pin drive; every enable falls when the port gives up the pins
  always_comb begin
    pin_out.sclk_o = sclk_ff;
    pin_out.sclk_oe = enable && master; // RQ4 RQ11
    pin_out.mosi_o = tx_ff[7];
    pin_out.mosi_oe = enable && master; // RQ3
    pin_out.miso_o = tx_ff[7];
    pin_out.miso_oe = selected; // RQ2 RQ21
  end

endmodule
